// ===== logic/wq_regs.svh
// Purpose: write queue constants
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef WQ_REGS_SVH
`define WQ_REGS_SVH
// queue geometry
`define WQ_ENTRIES 8
`define WQ_FIFO_DEPTH 16
// diagnostic alternate spaces
`define WQ_ASI_TAG 8'h30
`define WQ_ASI_DATA 8'h31
`define WQ_ASI_CTRL 8'h32
// control register field positions
`define WQ_CTL_SHADOW 8
`define WQ_CTL_DRAINED 7
`define WQ_CTL_PEND 6
`define WQ_CTL_HEAD_LSB 3
`define WQ_CTL_TAIL_LSB 0
// control register reset value, queue empty
`define WQ_CTL_RESET 32'h0000_0080
// entry tag field positions
`define WQ_TAG_BARRIER 42
`define WQ_TAG_BURST 41
`define WQ_TAG_VALID 40
`define WQ_TAG_SUP 39
`define WQ_TAG_CACHE 38
`define WQ_TAG_SIZE_LSB 36
// address slices: cache line and doubleword
`define WQ_LINE_LSB 5
`define WQ_DW_LSB 3
// data store error trap identity
`define WQ_TRAP_TYPE 8'h2B
`define WQ_TRAP_PRIO 4'h2
`endif

// ===== logic/wq_pkg.sv
// Purpose: types shared by the write queue modules
// Assumes: constants live in wq_regs.svh
// Notes: used as wq_pkg::name
package wq_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    WQ_IDLE = 4'h1,
    WQ_DRAIN = 4'h2,
    WQ_BACK = 4'h4,
    WQ_CTX = 4'h8
  } wq_state_t;
  // access width code held in each tag
  typedef enum logic [1:0] {
    WQ_SZ_BYTE = 2'h0,
    WQ_SZ_HALF = 2'h1,
    WQ_SZ_WORD = 2'h2,
    WQ_SZ_DW = 2'h3
  } wq_size_t;
  // one queue entry: tag plus data
  typedef struct packed {
    logic barrier;
    logic burst;
    logic valid;
    logic sup;
    logic cache;
    wq_size_t size;
    logic [35:0] addr;
    logic [63:0] data;
  } wq_entry_t;
  // write command toward the external cache
  typedef struct packed {
    logic [35:0] addr;
    logic [63:0] data;
    wq_size_t size;
    logic sup;
    logic cache;
    logic burst;
    logic bypass;
  } wq_cmd_t;
  // whole state of the queue core
  typedef struct packed {
    wq_entry_t [7:0] ent;
    logic [2:0] head;
    logic [2:0] tail;
    logic [3:0] outs;
    logic en;
    logic epend;
    logic pflag;
    logic [15:0] context_id;
    wq_state_t st;
    logic [63:0] rdata;
    logic ack;
    logic aerr;
  } wq_core_t;
endpackage : wq_pkg

// ===== logic/wq_fifo_if.sv
// Purpose: valid/ready carrier to the command fifo
// Assumes: one filler and one fifo
// Notes: width set by the instantiating module
`timescale 1ns/1ns
interface wq_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface : wq_fifo_if

// ===== logic/wq_fifo.sv
// Purpose: command fifo before the external port
// Assumes: DEPTH is a power of two
// Notes: flush empties it in one cycle, used when the queue freezes
`timescale 1ns/1ns
module wq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  wq_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  // storage and pointers with one wrap bit each
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } wq_fifo_st_t;
  wq_fifo_st_t cur_ff;
  wq_fifo_st_t nxt_cur;
  logic full;
  logic empty;
  // wrap bits differ with equal index: full
  assign full = (cur_ff.wp[AW] != cur_ff.rp[AW]) &&
                (cur_ff.wp[AW-1:0] == cur_ff.rp[AW-1:0]);
  assign empty = (cur_ff.wp == cur_ff.rp);
  assign f.in_ready = !full;
  assign f.out_valid = !empty;
  assign f.out_data = cur_ff.mem[cur_ff.rp[AW-1:0]];
  // push and pop; flush drops all
  always_comb
  begin
    nxt_cur = cur_ff;
    if (flush_i)
    begin
      nxt_cur.wp = '0;
      nxt_cur.rp = '0;
    end
    else
    begin
      if (f.in_valid && !full)
      begin
        nxt_cur.mem[cur_ff.wp[AW-1:0]] = f.in_data;
        nxt_cur.wp = cur_ff.wp + {{AW{1'b0}}, 1'b1};
      end
      if (f.out_ready && !empty)
        nxt_cur.rp = cur_ff.rp + {{AW{1'b0}}, 1'b1};
    end
  end
  // state register, synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end
endmodule : wq_fifo

// ===== logic/wq_store_queue.sv
// Purpose: eight-entry write queue, pipeline to external cache
// Assumes: pipeline holds a store request stable while it is stalled
// Notes: diagnostic access through the alternate-space port
`timescale 1ns/1ns
`include "wq_regs.svh"
module wq_store_queue #(
  parameter int FIFO_DEPTH = `WQ_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // store request from the pipeline
  input wire logic st_valid_i,
  input wire logic st_bypass_i,
  input wire logic st_tlb_miss_i,
  input wire logic [35:0] st_addr_i,
  input wire logic [63:0] st_data_i,
  input wire logic [1:0] st_size_i,
  input wire logic st_sup_i,
  input wire logic st_cache_i,
  input wire logic st_barrier_i,
  output logic st_ready_o,
  // load and fetch address checks
  input wire logic ld_valid_i,
  input wire logic [35:0] ld_addr_i,
  output logic ld_stall_o,
  input wire logic if_valid_i,
  input wire logic [35:0] if_addr_i,
  output logic if_stall_o,
  // context identifier write
  input wire logic ctx_wr_i,
  input wire logic [15:0] ctx_wdata_i,
  output logic ctx_done_o,
  output logic [15:0] context_id_o,
  // module control word enable bit
  input wire logic mcw_wr_i,
  input wire logic mcw_en_i,
  output logic write_queue_enable_o,
  // trap control
  input wire logic fault_mask_bit_i,
  input wire logic traps_en_i,
  input wire logic trap_taken_i,
  output logic trap_req_o,
  output logic [7:0] trap_type_o,
  output logic [3:0] trap_prio_o,
  // diagnostic alternate-space port
  input wire logic asi_req_i,
  input wire logic asi_wr_i,
  input wire logic [7:0] asi_i,
  input wire logic [31:0] asi_addr_i,
  input wire logic [63:0] asi_wdata_i,
  output logic asi_ack_o,
  output logic asi_err_o,
  output logic [63:0] asi_rdata_o,
  // write port toward the external cache
  output logic ext_valid_o,
  input wire logic ext_ready_i,
  output logic [35:0] ext_addr_o,
  output logic [63:0] ext_data_o,
  output logic [1:0] ext_size_o,
  output logic ext_sup_o,
  output logic ext_cache_o,
  output logic ext_burst_o,
  output logic ext_bypass_o,
  input wire logic ext_ack_i,
  input wire logic ext_err_i
);
  localparam int CW = $bits(wq_pkg::wq_cmd_t);
  wq_pkg::wq_core_t c_ff; // all state
  wq_pkg::wq_core_t nxt_c; // next state
  wq_pkg::wq_cmd_t cmd; // command pushed
  wq_pkg::wq_cmd_t ocmd; // command leaving the fifo
  logic [3:0] cnt; // valid entries
  logic full; // pointers equal with valid entries
  logic empty; // no valid entries
  logic [2:0] iss; // next entry to issue
  logic [2:0] prev; // entry written just before tail
  logic [2:0] sel; // diagnostic entry select
  logic push; // fifo push this cycle
  logic flush; // drop queued commands on a fault
  logic accept; // store enters the queue
  logic byp_done; // bypass store completed
  logic ld_hit; // load address matches
  logic if_hit; // fetch address matches
  wq_fifo_if #(.W(CW)) f ();
  // count, full and empty from the valid flags
  always_comb
  begin
    cnt = 4'h0;
    for (int i = 0; i < `WQ_ENTRIES; i++)
      cnt = cnt + {3'h0, c_ff.ent[i].valid};
    full = (c_ff.head == c_ff.tail) && (cnt != 4'h0);
    empty = (cnt == 4'h0);
  end
  // associative doubleword match; data never forwarded
  always_comb
  begin
    ld_hit = 1'b0;
    if_hit = 1'b0;
    for (int i = 0; i < `WQ_ENTRIES; i++)
    begin
      if (c_ff.ent[i].valid &&
          c_ff.ent[i].addr[35:`WQ_DW_LSB] == ld_addr_i[35:`WQ_DW_LSB])
        ld_hit = 1'b1;
      if (c_ff.ent[i].valid &&
          c_ff.ent[i].addr[35:`WQ_DW_LSB] == if_addr_i[35:`WQ_DW_LSB])
        if_hit = 1'b1;
    end
  end
  assign ld_stall_o = ld_valid_i && ld_hit;
  assign if_stall_o = if_valid_i && if_hit;
  // issue walks from head past the entries already in flight
  assign iss = c_ff.head + c_ff.outs[2:0];
  assign prev = c_ff.tail - 3'h1;
  assign sel = asi_addr_i[5:3];
  // a store queues only while enabled, not full and nothing waits
  assign accept = st_valid_i && !st_bypass_i && !st_tlb_miss_i &&
                  c_ff.en && !full && (c_ff.st == wq_pkg::WQ_IDLE);
  assign byp_done = (c_ff.st == wq_pkg::WQ_BACK) && (ext_ack_i || ext_err_i);
  assign st_ready_o = accept || byp_done;
  // a queued error freezes; acks while disabled are not ours
  assign flush = ext_err_i && c_ff.en && (c_ff.st != wq_pkg::WQ_BACK);
  // fifo push: bypass store, or next queued entry in order
  always_comb
  begin
    cmd = '0;
    push = 1'b0;
    if (c_ff.st == wq_pkg::WQ_DRAIN)
    begin
      // bypass waits for drain unless the queue is frozen
      if ((empty || !c_ff.en) && c_ff.outs == 4'h0)
      begin
        push = 1'b1;
        cmd.addr = st_addr_i;
        cmd.data = st_data_i;
        cmd.size = wq_pkg::wq_size_t'(st_size_i);
        cmd.sup = st_sup_i;
        cmd.cache = st_cache_i;
        cmd.bypass = 1'b1;
      end
    end
    else if (c_ff.en && !flush && c_ff.ent[iss].valid &&
             c_ff.outs < 4'h8)
    begin
      push = 1'b1;
      cmd.addr = c_ff.ent[iss].addr;
      cmd.data = c_ff.ent[iss].data;
      cmd.size = c_ff.ent[iss].size;
      cmd.sup = c_ff.ent[iss].sup;
      cmd.cache = c_ff.ent[iss].cache;
      cmd.burst = c_ff.ent[iss].burst;
    end
  end
  assign f.in_valid = push;
  assign f.in_data = cmd;
  assign f.out_ready = ext_ready_i;
  assign ocmd = wq_pkg::wq_cmd_t'(f.out_data);
  assign ext_valid_o = f.out_valid;
  assign ext_addr_o = ocmd.addr;
  assign ext_data_o = ocmd.data;
  assign ext_size_o = ocmd.size;
  assign ext_sup_o = ocmd.sup;
  assign ext_cache_o = ocmd.cache;
  assign ext_burst_o = ocmd.burst;
  assign ext_bypass_o = ocmd.bypass;
  // command fifo in front of the external write port
  wq_fifo #(
    .W(CW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .f(f)
  );
  // next state: software first, hardware events after so they win
  always_comb
  begin
    nxt_c = c_ff;
    nxt_c.ack = 1'b0;
    nxt_c.aerr = 1'b0;
    // module control word write of the enable bit
    if (mcw_wr_i)
      nxt_c.en = mcw_en_i;
    // diagnostic port, answered one cycle later
    if (asi_req_i)
    begin
      nxt_c.ack = 1'b1;
      nxt_c.rdata = 64'h0;
      unique case (asi_i)
        `WQ_ASI_CTRL:
        begin
          if (asi_wr_i)
          begin
            nxt_c.head = asi_wdata_i[`WQ_CTL_HEAD_LSB +: 3];
            nxt_c.tail = asi_wdata_i[`WQ_CTL_TAIL_LSB +: 3];
          end
          nxt_c.rdata[`WQ_CTL_SHADOW] = c_ff.en;
          nxt_c.rdata[`WQ_CTL_DRAINED] = empty;
          nxt_c.rdata[`WQ_CTL_PEND] = c_ff.pflag;
          nxt_c.rdata[`WQ_CTL_HEAD_LSB +: 3] = c_ff.head;
          nxt_c.rdata[`WQ_CTL_TAIL_LSB +: 3] = c_ff.tail;
        end
        `WQ_ASI_TAG:
        begin
          if (asi_addr_i[2:0] != 3'h0)
            nxt_c.aerr = 1'b1;
          else if (asi_wr_i)
          begin
            nxt_c.ent[sel].barrier = asi_wdata_i[`WQ_TAG_BARRIER];
            nxt_c.ent[sel].burst = asi_wdata_i[`WQ_TAG_BURST];
            nxt_c.ent[sel].valid = asi_wdata_i[`WQ_TAG_VALID];
            nxt_c.ent[sel].sup = asi_wdata_i[`WQ_TAG_SUP];
            nxt_c.ent[sel].cache = asi_wdata_i[`WQ_TAG_CACHE];
            nxt_c.ent[sel].size =
              wq_pkg::wq_size_t'(asi_wdata_i[`WQ_TAG_SIZE_LSB +: 2]);
            nxt_c.ent[sel].addr = asi_wdata_i[35:0];
          end
          nxt_c.rdata[`WQ_TAG_BARRIER] = c_ff.ent[sel].barrier;
          nxt_c.rdata[`WQ_TAG_BURST] = c_ff.ent[sel].burst;
          nxt_c.rdata[`WQ_TAG_VALID] = c_ff.ent[sel].valid;
          nxt_c.rdata[`WQ_TAG_SUP] = c_ff.ent[sel].sup;
          nxt_c.rdata[`WQ_TAG_CACHE] = c_ff.ent[sel].cache;
          nxt_c.rdata[`WQ_TAG_SIZE_LSB +: 2] = c_ff.ent[sel].size;
          nxt_c.rdata[35:0] = c_ff.ent[sel].addr;
        end
        `WQ_ASI_DATA:
        begin
          if (asi_addr_i[2:0] != 3'h0)
            nxt_c.aerr = 1'b1;
          else if (asi_wr_i)
            nxt_c.ent[sel].data = asi_wdata_i;
          nxt_c.rdata = c_ff.ent[sel].data;
        end
        default:
          nxt_c.aerr = 1'b1; // unknown space answers with an error
      endcase
    end
    // accepted store fills the tail entry
    if (accept)
    begin
      nxt_c.ent[c_ff.tail].valid = 1'b1;
      nxt_c.ent[c_ff.tail].barrier = st_barrier_i;
      nxt_c.ent[c_ff.tail].burst = 1'b0;
      nxt_c.ent[c_ff.tail].sup = st_sup_i;
      nxt_c.ent[c_ff.tail].cache = st_cache_i;
      nxt_c.ent[c_ff.tail].size = wq_pkg::wq_size_t'(st_size_i);
      nxt_c.ent[c_ff.tail].addr = st_addr_i;
      nxt_c.ent[c_ff.tail].data = st_data_i;
      nxt_c.tail = c_ff.tail + 3'h1;
      // previous entry in the same line continues as a burst
      if (c_ff.ent[prev].valid &&
          c_ff.ent[prev].addr[35:`WQ_LINE_LSB] == st_addr_i[35:`WQ_LINE_LSB])
        nxt_c.ent[prev].burst = 1'b1;
    end
    // count queued entries in flight
    if (push && f.in_ready && c_ff.st != wq_pkg::WQ_DRAIN)
      nxt_c.outs = c_ff.outs + 4'h1;
    // completion retires the head entry in order
    if (ext_ack_i && c_ff.en && c_ff.st != wq_pkg::WQ_BACK &&
        c_ff.outs != 4'h0)
    begin
      nxt_c.ent[c_ff.head].valid = 1'b0;
      nxt_c.head = c_ff.head + 3'h1;
      nxt_c.outs = nxt_c.outs - 4'h1;
    end
    // fault: freeze, disable, keep entries and pointers
    if (flush)
    begin
      nxt_c.en = 1'b0;
      nxt_c.outs = 4'h0;
      nxt_c.epend = 1'b1;
    end
    // trap taken clears pending, a same-cycle fault wins
    if (trap_taken_i && !flush)
    begin
      nxt_c.epend = 1'b0;
      nxt_c.pflag = 1'b0;
    end
    if (flush && !traps_en_i)
      nxt_c.pflag = 1'b1;
    // sequencer for synchronous stores and context writes
    unique case (c_ff.st)
      wq_pkg::WQ_IDLE:
      begin
        if (st_valid_i && !st_tlb_miss_i && (st_bypass_i || !c_ff.en))
          nxt_c.st = wq_pkg::WQ_DRAIN;
        else if (ctx_wr_i && !st_valid_i)
          nxt_c.st = wq_pkg::WQ_CTX;
      end
      wq_pkg::WQ_DRAIN:
      begin
        if (push && f.in_ready)
          nxt_c.st = wq_pkg::WQ_BACK;
      end
      wq_pkg::WQ_BACK:
      begin
        if (byp_done)
          nxt_c.st = wq_pkg::WQ_IDLE;
      end
      wq_pkg::WQ_CTX:
      begin
        // completes only once drained and no fault is unreported
        if (empty && c_ff.outs == 4'h0 && !c_ff.epend)
        begin
          nxt_c.context_id = ctx_wdata_i;
          nxt_c.st = wq_pkg::WQ_IDLE;
        end
      end
      default:
        nxt_c.st = wq_pkg::WQ_IDLE; // illegal code recovers to idle
    endcase
  end
  // done pulses as the context is written
  assign ctx_done_o = (c_ff.st == wq_pkg::WQ_CTX) && empty &&
                      (c_ff.outs == 4'h0) && !c_ff.epend;
  assign context_id_o = c_ff.context_id;
  assign write_queue_enable_o = c_ff.en;
  // trap only unmasked with traps on, else pending
  assign trap_req_o = c_ff.epend && !fault_mask_bit_i && traps_en_i;
  assign trap_type_o = `WQ_TRAP_TYPE;
  assign trap_prio_o = `WQ_TRAP_PRIO;
  assign asi_ack_o = c_ff.ack;
  assign asi_err_o = c_ff.aerr;
  assign asi_rdata_o = c_ff.rdata;
  // state register; reset empties and disables
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      c_ff <= '0;
      c_ff.st <= wq_pkg::WQ_IDLE;
    end
    else
      c_ff <= nxt_c;
  end
endmodule : wq_store_queue

// ===== bench/wq_ext_model.sv
// Purpose: external cache write port model
// Assumes: completions come back in order, one pulse each
// Notes: err_arm_i answers with errors
`timescale 1ns/1ns
module wq_ext_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_valid_i,
  input wire logic [35:0] ext_addr_i,
  input wire logic ext_bypass_i,
  input wire logic stall_i,
  input wire logic err_arm_i,
  output logic ext_ready_o,
  output logic ext_ack_o,
  output logic ext_err_o
);
  int pend; // accepted writes still owed a completion
  logic [36:0] log[$]; // bypass flag and address per write
  logic take; // a write is popped this cycle
  // stall holds ready low and delays completions
  assign ext_ready_o = !stall_i;
  assign take = ext_valid_i && ext_ready_o;
  // one completion at a time; an error drops the rest
  always @(posedge clk_i)
  begin
    ext_ack_o <= 1'b0;
    ext_err_o <= 1'b0;
    if (take)
      log.push_back({ext_bypass_i, ext_addr_i});
    if (!rst_n_i)
      pend <= 0;
    else if (pend > 0 && !ext_ack_o && !ext_err_o && !stall_i)
    begin
      ext_ack_o <= !err_arm_i;
      ext_err_o <= err_arm_i;
      pend <= err_arm_i ? 0 : pend - 1 + int'(take);
    end
    else
      pend <= pend + int'(take);
  end
endmodule : wq_ext_model

// ===== bench/wq_store_queue_chk.sv
// Purpose: port-level temporal checks of the write queue
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top
`timescale 1ns/1ns
module wq_store_queue_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic st_valid_i,
  input wire logic st_bypass_i,
  input wire logic st_tlb_miss_i,
  input wire logic st_ready_o,
  input wire logic ld_stall_o,
  input wire logic ctx_done_o,
  input wire logic [15:0] ctx_wdata_i,
  input wire logic [15:0] context_id_o,
  input wire logic mcw_wr_i,
  input wire logic write_queue_enable_o,
  input wire logic fault_mask_bit_i,
  input wire logic traps_en_i,
  input wire logic trap_req_o,
  input wire logic [7:0] trap_type_o,
  input wire logic [3:0] trap_prio_o,
  input wire logic asi_req_i,
  input wire logic [7:0] asi_i,
  input wire logic [31:0] asi_addr_i,
  input wire logic asi_ack_o,
  input wire logic asi_err_o,
  input wire logic [63:0] asi_rdata_o,
  input wire logic ext_valid_o,
  input wire logic ext_err_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // a trap carries the store error identity
  a_trap_code: assert property (
    trap_req_o |-> trap_type_o == 8'h2B && trap_prio_o == 4'h2)
    else $error("trap type or priority wrong");
  // suppressed errors stay silent
  a_trap_gate: assert property (
    trap_req_o |-> !fault_mask_bit_i && traps_en_i)
    else $error("trap while suppressed");
  // a write error while enabled and outside a bypass store freezes
  a_fault_freeze: assert property (
    ext_err_i && write_queue_enable_o && !mcw_wr_i && !(st_valid_i && st_bypass_i)
    |=> !write_queue_enable_o)
    else $error("enabled after write error");
  a_store_cause: assert property (
    st_ready_o |-> st_valid_i && (st_bypass_i || !write_queue_enable_o || !st_tlb_miss_i))
    else $error("store answered without request");
  a_diag_ack: assert property (
    asi_req_i |=> asi_ack_o)
    else $error("diagnostic access unanswered");
  a_tag_misalign: assert property (
    asi_req_i && asi_i == 8'h30 && asi_addr_i[2:0] != 3'h0 |=> asi_ack_o && asi_err_o)
    else $error("misaligned tag access not refused");
  a_enable_mirror: assert property (
    asi_ack_o && $past(asi_i) == 8'h32 |-> asi_rdata_o[8] == $past(write_queue_enable_o))
    else $error("control bit 8 differs from enable");
  // context changes only when drained
  a_ctx_drained: assert property (
    ctx_done_o |-> !ext_valid_o && !ld_stall_o)
    else $error("context written too early");
  a_ctx_value: assert property (
    ctx_done_o |=> context_id_o == $past(ctx_wdata_i))
    else $error("context value not taken");
  c_store: cover property (st_valid_i && st_ready_o && !st_bypass_i);
  c_trap: cover property (trap_req_o);
  c_ctx: cover property (ctx_done_o);
  c_diag_err: cover property (asi_ack_o && asi_err_o);
endmodule : wq_store_queue_chk

// ===== bench/wq_store_queue_test.sv
// Purpose: directed bench of the write queue
// Assumes: inputs change at the falling edge
// Notes: expectations follow the running sequence
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); end end
module wq_store_queue_test;
  logic clk_i, rst_n_i, st_valid_i, st_bypass_i, st_tlb_miss_i, st_sup_i, st_cache_i;
  logic st_barrier_i, st_ready_o, ld_valid_i, ld_stall_o, if_valid_i, if_stall_o;
  logic [35:0] st_addr_i, ld_addr_i, if_addr_i, ext_addr_o;
  logic [63:0] st_data_i, asi_wdata_i, asi_rdata_o, ext_data_o, rd;
  logic [1:0] st_size_i, ext_size_o;
  logic ctx_wr_i, ctx_done_o, mcw_wr_i, mcw_en_i, write_queue_enable_o;
  logic [15:0] ctx_wdata_i, context_id_o;
  logic fault_mask_bit_i, traps_en_i, trap_taken_i, trap_req_o, asi_req_i, asi_wr_i;
  logic [7:0] trap_type_o, asi_i;
  logic [3:0] trap_prio_o;
  logic asi_ack_o, asi_err_o, ext_valid_o, ext_ready_i, ext_sup_o, ext_cache_o;
  logic [31:0] asi_addr_i;
  logic ext_burst_o, ext_bypass_o, ext_ack_i, ext_err_i, stall, err_arm, ok, er;
  logic [35:0] adr[4] = '{36'h100, 36'h108, 36'h110, 36'h200}; // last one opens a new line
  int n_fail, check_count, cyc, w;
  wq_store_queue #(.FIFO_DEPTH(16)) dut (.*);
  wq_ext_model ext (.clk_i, .rst_n_i, .ext_valid_i(ext_valid_o), .ext_addr_i(ext_addr_o),
    .ext_bypass_i(ext_bypass_o), .stall_i(stall), .err_arm_i(err_arm),
    .ext_ready_o(ext_ready_i), .ext_ack_o(ext_ack_i), .ext_err_o(ext_err_i));
  // 125 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // hang guard, sequence needs under 1000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  // diagnostic access, answer by next falling edge
  task automatic asi(input logic wr, input logic [7:0] a, input logic [31:0] ad,
                     input logic [63:0] wd);
    @(negedge clk_i);
    asi_req_i = 1'b1;
    asi_wr_i = wr;
    asi_i = a;
    asi_addr_i = ad;
    asi_wdata_i = wd;
    @(negedge clk_i);
    asi_req_i = 1'b0;
    rd = asi_rdata_o;
    er = asi_err_o;
  endtask : asi
  // wait for a comb answer; w counts cycles
  task automatic wait_ans(input logic context_id, input int lim);
    ok = 1'b0;
    w = 0;
    while (!ok && w < lim)
    begin
      #2;
      ok = context_id ? (ctx_done_o === 1'b1) : (st_ready_o === 1'b1);
      @(negedge clk_i);
      w++;
    end
    st_valid_i = 1'b0;
    st_bypass_i = 1'b0;
    ctx_wr_i = 1'b0;
  endtask : wait_ans
  // store request held until taken
  task automatic store(input logic [35:0] a, input logic [1:0] sz, input logic bar,
                       input logic bp, input int lim);
    @(negedge clk_i);
    st_valid_i = 1'b1;
    st_addr_i = a;
    st_data_i = {28'h0, a};
    st_size_i = sz;
    st_barrier_i = bar;
    st_bypass_i = bp;
    wait_ans(1'b0, lim);
  endtask : store
  task automatic mcw(input logic v);
    @(negedge clk_i);
    mcw_wr_i = 1'b1;
    mcw_en_i = v;
    @(negedge clk_i);
    mcw_wr_i = 1'b0;
  endtask : mcw
  task automatic ctl(input logic [63:0] e);
    asi(1'b0, 8'h32, 32'h0, 64'h0);
    `CHK("control", e, rd)
  endtask : ctl
  task automatic take_trap();
    @(negedge clk_i);
    trap_taken_i = 1'b1;
    @(negedge clk_i);
    trap_taken_i = 1'b0;
  endtask : take_trap
  // main sequence
  initial
  begin
    {rst_n_i, st_valid_i, st_bypass_i, st_tlb_miss_i, st_barrier_i, ld_valid_i, if_valid_i,
     ctx_wr_i, mcw_wr_i, mcw_en_i, fault_mask_bit_i, trap_taken_i, asi_req_i, asi_wr_i,
     stall, err_arm} = '0;
    {st_addr_i, ld_addr_i, if_addr_i, st_data_i, asi_wdata_i, st_size_i} = '0;
    {ctx_wdata_i, asi_i, asi_addr_i} = '0;
    {st_sup_i, st_cache_i, traps_en_i} = 3'h7;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    ctl(64'h80);
    mcw(1'b1);
    ctl(64'h180);
    $display("test reset done");
    // a miss holds the first store, the rest enter at once
    stall = 1'b1;
    st_tlb_miss_i = 1'b1;
    fork
      store(adr[0], 2'h0, 1'b0, 1'b0, 40);
      begin
        repeat (4) @(negedge clk_i);
        st_tlb_miss_i = 1'b0;
      end
    join
    `CHK("miss hold", 1'b1, w > 3)
    for (int i = 1; i < 4; i++)
    begin
      store(adr[i], 2'(i), i == 3, 1'b0, 5);
      `CHK("store at once", 1'b1, w == 1)
    end
    ld_valid_i = 1'b1;
    ld_addr_i = 36'h10C;
    if_valid_i = 1'b1;
    if_addr_i = 36'h204;
    #2;
    `CHK("load match", 1'b1, ld_stall_o)
    `CHK("fetch match", 1'b1, if_stall_o)
    ld_addr_i = 36'h118;
    #1;
    `CHK("load other", 1'b0, ld_stall_o)
    for (int i = 0; i < 4; i++)
    begin
      asi(1'b0, 8'h30, 32'(i * 8), 64'h0);
      `CHK("tag", {21'h0, i == 3, i < 2, 3'h7, 2'(i), adr[i]}, rd)
    end
    ctl(64'h104);
    stall = 1'b0;
    repeat (20) @(negedge clk_i);
    `CHK("load after drain", 1'b0, ld_stall_o)
    `CHK("fetch after drain", 1'b0, if_stall_o)
    for (int i = 0; i < 4; i++)
      `CHK("issue order", {1'b0, adr[i]}, ext.log[i])
    ctl(64'h1A4);
    $display("test order done");
    // fill eight entries, the ninth waits
    stall = 1'b1;
    for (int i = 0; i < 8; i++)
      store(36'h1000 + 36'(i * 64), 2'h3, 1'b0, 1'b0, 5);
    ctl(64'h124);
    fork
      store(36'h2000, 2'h3, 1'b0, 1'b0, 40);
      begin
        repeat (10) @(negedge clk_i);
        stall = 1'b0;
      end
    join
    `CHK("full hold", 1'b1, w > 10)
    repeat (30) @(negedge clk_i);
    `CHK("drained count", 13, ext.log.size())
    ctl(64'h1AD);
    $display("test full done");
    // fault with traps on, then re-enable
    err_arm = 1'b1;
    store(36'h300, 2'h3, 1'b0, 1'b0, 5);
    repeat (6) @(negedge clk_i);
    err_arm = 1'b0;
    `CHK("enable cleared", 1'b0, write_queue_enable_o)
    `CHK("trap raised", 1'b1, trap_req_o)
    `CHK("trap type", 8'h2B, trap_type_o)
    ctl(64'h2E);
    asi(1'b0, 8'h30, 32'h28, 64'h0);
    `CHK("faulted entry kept", {21'h0, 5'h7, 2'h3, 36'h300}, rd)
    take_trap();
    `CHK("trap cleared", 1'b0, trap_req_o)
    store(36'h400, 2'h3, 1'b0, 1'b0, 40);
    `CHK("sync store", {1'b1, 36'h400}, ext.log[14])
    mcw(1'b1);
    repeat (10) @(negedge clk_i);
    `CHK("reissue", {1'b0, 36'h300}, ext.log[15])
    ctl(64'h1B6);
    $display("test fault done");
    // fault with traps off, then software restart
    traps_en_i = 1'b0;
    err_arm = 1'b1;
    store(36'h500, 2'h3, 1'b0, 1'b0, 5);
    repeat (6) @(negedge clk_i);
    err_arm = 1'b0;
    `CHK("masked disable", 1'b0, write_queue_enable_o)
    `CHK("no trap", 1'b0, trap_req_o)
    ctl(64'h77);
    fault_mask_bit_i = 1'b1;
    traps_en_i = 1'b1;
    #1;
    `CHK("still masked", 1'b0, trap_req_o)
    fault_mask_bit_i = 1'b0;
    #1;
    `CHK("pending trap", 1'b1, trap_req_o)
    take_trap();
    ctl(64'h37);
    asi(1'b1, 8'h30, 32'h30, 64'h0);
    asi(1'b1, 8'h32, 32'h0, 64'h3F);
    mcw(1'b1);
    ctl(64'h1BF);
    $display("test masked done");
    // a bypass store waits behind queued stores
    stall = 1'b1;
    store(36'h600, 2'h3, 1'b0, 1'b0, 5);
    fork
      store(36'h700, 2'h3, 1'b0, 1'b1, 40);
      begin
        repeat (6) @(negedge clk_i);
        stall = 1'b0;
      end
    join
    `CHK("bypass waits", 1'b1, w > 6)
    `CHK("queued first", {1'b0, 36'h600}, ext.log[17])
    `CHK("bypass last", {1'b1, 36'h700}, ext.log[18])
    // a context write waits for the drain
    stall = 1'b1;
    store(36'h800, 2'h3, 1'b0, 1'b0, 5);
    fork
      begin
        @(negedge clk_i);
        ctx_wr_i = 1'b1;
        ctx_wdata_i = 16'hA5C3;
        wait_ans(1'b1, 60);
      end
      begin
        repeat (8) @(negedge clk_i);
        stall = 1'b0;
      end
    join
    `CHK("context waits", 1'b1, w > 8)
    `CHK("context value", 16'hA5C3, context_id_o)
    $display("test bypass and context done");
    // diagnostic refusals and ignored upper address bits
    asi(1'b0, 8'h30, 32'h4, 64'h0);
    `CHK("tag misaligned", 1'b1, er)
    asi(1'b0, 8'h33, 32'h0, 64'h0);
    `CHK("unknown space", 1'b1, er)
    asi(1'b1, 8'h30, 32'hABCD_0038, 64'hFFFF_F8A0_0000_09A8);
    asi(1'b0, 8'h30, 32'h38, 64'h0);
    `CHK("tag readback", 64'h0000_00A0_0000_09A8, rd)
    $display("test diagnostic done");
    give_verdict();
  end
endmodule : wq_store_queue_test
bind wq_store_queue wq_store_queue_chk chk (.*);
